// ==== scd_coil_model.sv ====
// Purpose: Behavioural coil and current comparator behind the bridge
// Assumes: One current step per clock
// Notes:   Steep charge, slow fall, so decay starts mid-period
`timescale 1ns/100ps
module scd_coil_model (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire scd_pkg::scd_bridge_s bridge_i,
    input  wire logic [7:0]           set_i,
    output logic                      coil_below_o
);
    logic [7:0] lvl_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_q <= 8'h00;
        end else if (bridge_i.en && bridge_i.charge) begin
            lvl_q <= (lvl_q > 8'hFD) ? 8'hFF : lvl_q + 8'h02;
        end else if (lvl_q != 8'h00) begin
            lvl_q <= lvl_q - 8'h01;
        end
    end
    assign coil_below_o = lvl_q < set_i;
endmodule

// ==== scd_idle_det.sv ====
// Purpose: Step idle detector driving the hold-current reduce request
// Assumes: step_i synchronous to clk_i
// Notes:   A zero timeout asserts hold one cycle after the last step edge
`timescale 1ns/100ps
module scd_idle_det (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        step_i,
    input  wire logic [31:0] timeout_i,
    output logic             hold_o,
    output logic             hold_set_o
);

    logic        step_q;
    logic [31:0] cnt_q;
    logic        step_rise;

    assign step_rise = step_i & ~step_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_q <= 1'b0;
        end else begin
            step_q <= step_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 32'h0000_0000;
        end else if (step_rise) begin
            cnt_q <= 32'h0000_0000;
        end else if (!hold_o && cnt_q < timeout_i) begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_o     <= 1'b0;
            hold_set_o <= 1'b0;
        end else begin
            hold_set_o <= 1'b0;
            if (step_rise) begin
                hold_o <= 1'b0;
            end else if (!hold_o && cnt_q >= timeout_i) begin
                hold_o     <= 1'b1;
                hold_set_o <= 1'b1;
            end
        end
    end

endmodule

// ==== scd_monitor.sv ====
// Purpose: Port checker for the chopping decay controller
// Assumes: One clock, synchronous active-high reset
// Notes:   Period age counted from the sampled oscillator rise
`timescale 1ns/100ps
module scd_monitor (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 chop_osc_i,
    input wire logic                 short_det_i,
    input wire logic                 standby_control_i,
    input wire logic                 step_i,
    input wire scd_pkg::scd_bridge_s bridge_o,
    input wire logic                 fault_output_oe_n_o,
    input wire logic                 hold_reduce_oe_n_o
);
    logic       osc_q;
    logic [7:0] since_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Saturates so long periods never look like a fresh start
    always_ff @(posedge clk_i) begin
        osc_q <= chop_osc_i;
        if (rst_i) begin
            since_q <= 8'hFF;
        end else if (chop_osc_i && !osc_q) begin
            since_q <= 8'h01;
        end else if (since_q != 8'hFF) begin
            since_q <= since_q + 8'h01;
        end
    end
    blank_hold_a: assert property (
        bridge_o.en && since_q inside {[8'h04:8'h64]} |-> bridge_o.charge)
        else $error("charge left inside blanking");
    decay_sticky_a: assert property (
        bridge_o.en && since_q > 8'h02 && $past(bridge_o.slow | bridge_o.fast)
        |-> !bridge_o.charge) else $error("charge after decay");
    fast_final_a: assert property (
        bridge_o.en && since_q > 8'h02 && $past(bridge_o.fast)
        |-> !bridge_o.slow) else $error("slow after fast decay");
    short_off_a: assert property (
        short_det_i && bridge_o.en |-> ##[1:3] !bridge_o.en)
        else $error("bridge not off on short");
    latch_off_a: assert property (
        !fault_output_oe_n_o && !$past(fault_output_oe_n_o) |-> !bridge_o.en)
        else $error("bridge on while latched");
    latch_hold_a: assert property (
        !fault_output_oe_n_o && standby_control_i && $past(standby_control_i)
        && $past(standby_control_i, 2) |=> !fault_output_oe_n_o)
        else $error("latch released without standby low");
    fault_release_a: assert property (
        $rose(fault_output_oe_n_o) |-> !$past(standby_control_i)
        || !$past(standby_control_i, 2)) else $error("fault cleared early");
    hold_release_a: assert property (
        $rose(step_i) && !hold_reduce_oe_n_o |-> ##[1:2] hold_reduce_oe_n_o)
        else $error("hold not released by step");
    hold_idle_a: assert property (
        $fell(hold_reduce_oe_n_o) |-> $past(step_i) == $past(step_i, 2))
        else $error("hold asserted at a step edge");
    cover property (bridge_o.en && $past(bridge_o.slow) && bridge_o.fast);
    cover property ($fell(fault_output_oe_n_o));
    cover property ($fell(hold_reduce_oe_n_o));
endmodule

bind scd_top scd_monitor mon_u (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .chop_osc_i          (chop_osc_i),
    .short_det_i         (short_det_i),
    .standby_control_i   (standby_control_i),
    .step_i              (step_i),
    .bridge_o            (bridge_o),
    .fault_output_oe_n_o (fault_output_oe_n_o),
    .hold_reduce_oe_n_o  (hold_reduce_oe_n_o)
);

// ==== scd_pkg.sv ====
// Purpose: Shared constants and types for the chopping decay controller
// Assumes: 100 MHz clock, 32-bit classic Wishbone register access
// Notes:   Timing counts derive from times held in their own units, except the literal IDLE_RST
//
// Functional notes
// - High style code selects slow decay regulation
// - Low style code selects fast decay regulation
// - Middle or open code selects mixed decay
// - Oscillator rising edge starts charge, new period
// - Charge forced through blanking, comparator ignored
// - Slow: charge until reached, slow to end
// - Fast: charge until reached, fast to end
// - Mixed: record any below-set sample while blanking
// - Mixed below: charge, slow, fast in tail
// - Mixed never below: fast after blanking to end
// - Short turns bridge off, retry after timer
// - Short on retry latches off, asserts fault
// - Standby low alone releases the latched shutdown
// - Hold-reduce pulled low after step idle timeout
// - Next step edge releases hold, restarts timing
// - Idle timeout is capacitor times fixed factor; the code counts the IDLE register value directly in cycles
package scd_pkg;

    localparam int CLK_MHZ      = 100;
    localparam int BLANK_NS     = 1000;
    localparam int BLANK_CYC    = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int TAIL_NS      = 1000;
    localparam int TAIL_CYC     = (TAIL_NS * CLK_MHZ) / 1000;
    localparam int RETRY_US     = 256;
    localparam int RETRY_CYC    = RETRY_US * CLK_MHZ;
    // Tdown = C x 0.4e9 s/F, i.e. 400000 ns for each pF
    localparam int TDOWN_NS_PF  = 400000;
    localparam int CYC_PER_PF   = (TDOWN_NS_PF / 1000) * CLK_MHZ;
    localparam logic [15:0] CAP_PF_RST = 16'h05DC;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IDLE = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQS = 8'h0C;
    localparam logic [7:0] ADDR_IRQM = 8'h10;

    localparam int CTRL_EN_BIT  = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [3:0]  IRQM_RST = 4'h0;

    localparam int IRQ_SHORT    = 0;
    localparam int IRQ_LATCH    = 1;
    localparam int IRQ_HOLD     = 2;
    localparam int IRQ_RETRY_OK = 3;
    localparam int IRQ_W        = 4;

    typedef enum logic [1:0] {
        STYLE_MIXED = 2'b00,
        STYLE_SLOW  = 2'b01,
        STYLE_FAST  = 2'b10,
        STYLE_OPEN  = 2'b11
    } scd_style_e;

    typedef enum logic [1:0] {
        PH_CHARGE = 2'b00,
        PH_SLOW   = 2'b01,
        PH_FAST   = 2'b10,
        PH_IDLE   = 2'b11
    } scd_phase_e;

    typedef enum logic [1:0] {
        PROT_RUN   = 2'b00,
        PROT_WAIT  = 2'b01,
        PROT_CHECK = 2'b10,
        PROT_LATCH = 2'b11
    } scd_prot_e;

    typedef struct packed {
        logic en;
        logic charge;
        logic slow;
        logic fast;
    } scd_bridge_s;

    function automatic logic [31:0] tdown_cycles(input logic [15:0] pf);
        tdown_cycles = 32'(pf) * 32'(CYC_PER_PF);
    endfunction

    localparam logic [31:0] IDLE_RST = 32'h0393_8700;

    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        apply_sel = r;
    endfunction

endpackage

// ==== scd_top.sv ====
// Purpose: Per-period chopping, short protection and idle hold control
// Assumes: All pin inputs synchronous to clk_i; classic Wishbone slave
// Notes:   Mixed tail length uses the previous period's measured length
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/100ps
module scd_top #(
    parameter int RETRY_CYCLES = scd_pkg::RETRY_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               chop_osc_i,
    input  wire logic [1:0]         decay_select_i,
    input  wire logic               coil_below_i,
    input  wire logic               short_det_i,
    input  wire logic               standby_control_i,
    input  wire logic               step_i,
    output scd_pkg::scd_bridge_s    bridge_o,
    output logic                    fault_output_o,
    output logic                    fault_output_oe_n_o,
    output logic                    hold_reduce_o,
    output logic                    hold_reduce_oe_n_o,
    output logic                    irq_o
);

    // Register state
    logic [31:0]                ctrl_q;
    logic [31:0]                idle_q;
    logic [scd_pkg::IRQ_W-1:0]  irqs_q;
    logic [scd_pkg::IRQ_W-1:0]  irqm_q;

    // Chopping state
    scd_pkg::scd_phase_e        phase_q;
    scd_pkg::scd_style_e        style_q;
    logic                       osc_q;
    logic [15:0]                blank_q;
    logic                       below_seen_q;
    logic [15:0]                per_cnt_q;
    logic [15:0]                prev_len_q;

    // Protection state
    scd_pkg::scd_prot_e         prot_q;
    logic [31:0]                retry_q;

    // Idle detector
    logic                       hold;
    logic                       hold_set;

    logic                       bus_req;
    logic                       wr_en;
    logic                       rd_en;
    logic                       period_start;
    logic                       blanking;
    logic                       in_tail;
    logic                       outputs_on;
    logic                       chop_en;
    logic [scd_pkg::IRQ_W-1:0]  irq_evt;
    logic [31:0]                stat_word;

    assign bus_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en        = bus_req & wb_we_i;
    assign rd_en        = bus_req & ~wb_we_i;
    assign period_start = chop_osc_i & ~osc_q;
    assign blanking     = blank_q < 16'(scd_pkg::BLANK_CYC);
    assign in_tail      = prev_len_q > 16'(scd_pkg::TAIL_CYC) &&
                          per_cnt_q >=
                          prev_len_q - 16'(scd_pkg::TAIL_CYC);
    assign outputs_on   = prot_q == scd_pkg::PROT_RUN ||
                          prot_q == scd_pkg::PROT_CHECK;
    assign chop_en      = ctrl_q[scd_pkg::CTRL_EN_BIT];

    scd_idle_det u_idle (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .step_i     (step_i),
        .timeout_i  (idle_q),
        .hold_o     (hold),
        .hold_set_o (hold_set)
    );

    // Wishbone slave: one wait state, ack for every address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= scd_pkg::CTRL_RST;
            idle_q <= scd_pkg::IDLE_RST;
            irqm_q <= scd_pkg::IRQM_RST;
        end else if (wr_en) begin
            unique case (wb_adr_i)
                scd_pkg::ADDR_CTRL: begin
                    ctrl_q <= scd_pkg::apply_sel(ctrl_q, wb_dat_i,
                                                 wb_sel_i) & 32'h0000_0001;
                end
                scd_pkg::ADDR_IDLE: begin
                    idle_q <= scd_pkg::apply_sel(idle_q, wb_dat_i,
                                                 wb_sel_i);
                end
                scd_pkg::ADDR_IRQM: begin
                    if (wb_sel_i[0]) begin
                        irqm_q <= wb_dat_i[scd_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    assign stat_word = {20'h0_0000,
                        hold, prot_q, below_seen_q,
                        style_q, phase_q, 4'h0};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (wb_adr_i)
                scd_pkg::ADDR_CTRL: wb_dat_o <= ctrl_q;
                scd_pkg::ADDR_IDLE: wb_dat_o <= idle_q;
                scd_pkg::ADDR_STAT: wb_dat_o <= stat_word;
                scd_pkg::ADDR_IRQS: wb_dat_o <= 32'(irqs_q);
                scd_pkg::ADDR_IRQM: wb_dat_o <= 32'(irqm_q);
                default:            wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Sticky events; a new event in the read cycle survives the clear
    always_comb begin
        irq_evt = '0;
        irq_evt[scd_pkg::IRQ_SHORT] = prot_q == scd_pkg::PROT_RUN &&
                                      short_det_i;
        irq_evt[scd_pkg::IRQ_LATCH] = prot_q == scd_pkg::PROT_CHECK &&
                                      short_det_i;
        irq_evt[scd_pkg::IRQ_RETRY_OK] = prot_q == scd_pkg::PROT_CHECK &&
                                         !short_det_i;
        irq_evt[scd_pkg::IRQ_HOLD]  = hold_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irqs_q <= '0;
        end else if (rd_en && wb_adr_i == scd_pkg::ADDR_IRQS) begin
            irqs_q <= irq_evt;
        end else begin
            irqs_q <= irqs_q | irq_evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((irqs_q | irq_evt) & irqm_q);
        end
    end

    // Oscillator edge and period measurement
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_q      <= 1'b0;
            per_cnt_q  <= 16'h0000;
            prev_len_q <= 16'h0000;
        end else begin
            osc_q <= chop_osc_i;
            if (period_start) begin
                per_cnt_q  <= 16'h0000;
                prev_len_q <= per_cnt_q;
            end else if (per_cnt_q != 16'hFFFF) begin
                per_cnt_q <= per_cnt_q + 16'h0001;
            end
        end
    end

    // Style only changes at a period boundary
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            style_q <= scd_pkg::STYLE_MIXED;
        end else if (period_start) begin
            style_q <= scd_pkg::scd_style_e'(decay_select_i);
        end
    end

    // Blanking timer and below-set record
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blank_q      <= 16'(scd_pkg::BLANK_CYC);
            below_seen_q <= 1'b0;
        end else if (period_start) begin
            blank_q      <= 16'h0001;
            below_seen_q <= coil_below_i;
        end else if (blanking) begin
            blank_q      <= blank_q + 16'h0001;
            below_seen_q <= below_seen_q | coil_below_i;
        end
    end

    // Phase sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= scd_pkg::PH_IDLE;
        end else if (!chop_en || !outputs_on) begin
            phase_q <= scd_pkg::PH_IDLE;
        end else if (period_start) begin
            phase_q <= scd_pkg::PH_CHARGE;
        end else if (prot_q == scd_pkg::PROT_CHECK &&
                     phase_q == scd_pkg::PH_IDLE) begin
            // Retry must drive the bridge or a short is never seen
            phase_q <= scd_pkg::PH_CHARGE;
        end else begin
            unique case (phase_q)
                scd_pkg::PH_CHARGE: begin
                    if (blanking) begin
                        phase_q <= scd_pkg::PH_CHARGE;
                    end else begin
                        unique case (style_q)
                            scd_pkg::STYLE_SLOW: begin
                                if (!coil_below_i) begin
                                    phase_q <= scd_pkg::PH_SLOW;
                                end
                            end
                            scd_pkg::STYLE_FAST: begin
                                if (!coil_below_i) begin
                                    phase_q <= scd_pkg::PH_FAST;
                                end
                            end
                            scd_pkg::STYLE_MIXED,
                            scd_pkg::STYLE_OPEN: begin
                                if (!below_seen_q) begin
                                    phase_q <= scd_pkg::PH_FAST;
                                end else if (!coil_below_i) begin
                                    phase_q <= in_tail ?
                                               scd_pkg::PH_FAST :
                                               scd_pkg::PH_SLOW;
                                end
                            end
                        endcase
                    end
                end
                scd_pkg::PH_SLOW: begin
                    // Mixed adds a fast tail to pull ripple back down
                    if (style_q != scd_pkg::STYLE_SLOW &&
                        style_q != scd_pkg::STYLE_FAST && in_tail) begin
                        phase_q <= scd_pkg::PH_FAST;
                    end
                end
                scd_pkg::PH_FAST: begin
                    phase_q <= scd_pkg::PH_FAST;
                end
                scd_pkg::PH_IDLE: begin
                    // Wait for the next period start after a stop
                    phase_q <= scd_pkg::PH_IDLE;
                end
            endcase
        end
    end

    // Short protection with one retry, then latched shutdown
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_q  <= scd_pkg::PROT_RUN;
            retry_q <= 32'h0000_0000;
        end else begin
            unique case (prot_q)
                scd_pkg::PROT_RUN: begin
                    if (short_det_i) begin
                        prot_q  <= scd_pkg::PROT_WAIT;
                        retry_q <= 32'h0000_0000;
                    end
                end
                scd_pkg::PROT_WAIT: begin
                    if (retry_q >= 32'(RETRY_CYCLES - 1)) begin
                        prot_q <= scd_pkg::PROT_CHECK;
                    end else begin
                        retry_q <= retry_q + 32'h0000_0001;
                    end
                end
                scd_pkg::PROT_CHECK: begin
                    // One look after re-enable decides latch or run
                    if (short_det_i) begin
                        prot_q <= scd_pkg::PROT_LATCH;
                    end else begin
                        prot_q <= scd_pkg::PROT_RUN;
                    end
                end
                scd_pkg::PROT_LATCH: begin
                    if (!standby_control_i) begin
                        prot_q <= scd_pkg::PROT_RUN;
                    end
                end
            endcase
        end
    end

    // Registered pin drive; open-drain pins only ever pull low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bridge_o            <= '0;
            fault_output_o      <= 1'b0;
            fault_output_oe_n_o <= 1'b1;
            hold_reduce_o       <= 1'b0;
            hold_reduce_oe_n_o  <= 1'b1;
        end else begin
            bridge_o.en     <= outputs_on && phase_q != scd_pkg::PH_IDLE;
            bridge_o.charge <= outputs_on && phase_q == scd_pkg::PH_CHARGE;
            bridge_o.slow   <= outputs_on && phase_q == scd_pkg::PH_SLOW;
            bridge_o.fast   <= outputs_on && phase_q == scd_pkg::PH_FAST;
            fault_output_o  <= 1'b0;
            fault_output_oe_n_o <= prot_q != scd_pkg::PROT_LATCH;
            hold_reduce_o       <= 1'b0;
            hold_reduce_oe_n_o  <= !hold;
        end
    end

endmodule

// ==== scd_top_tb_top.sv ====
// Purpose: Self-checking bench for the chopping decay controller
// Assumes: Retry shortened to 64 cycles; idle timeout set by register
// Notes:   Style rows in a loop, protection and idle hold by hand
`timescale 1ns/100ps
module scd_top_tb_top;
    localparam int RETRY = 64;
    typedef struct packed {
        logic [1:0] st;
        logic [7:0] lvl;
        logic [3:0] mid;
        logic [3:0] tail;
    } scd_row_s;
    // One 400-cycle period per row; next row's style lands mid-period
    localparam scd_row_s ROWS [6] = '{
        '{scd_pkg::STYLE_SLOW,  8'hFF, 4'hA, 4'hA},
        '{scd_pkg::STYLE_SLOW,  8'h00, 4'hA, 4'hA},
        '{scd_pkg::STYLE_FAST,  8'hFF, 4'h9, 4'h9},
        '{scd_pkg::STYLE_MIXED, 8'hFF, 4'hA, 4'h9},
        '{scd_pkg::STYLE_MIXED, 8'h00, 4'h9, 4'h9},
        '{scd_pkg::STYLE_OPEN,  8'hFF, 4'hA, 4'h9}
    };
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 stb   = 1'b0;
    logic                 we    = 1'b0;
    logic [7:0]           adr   = 8'h00;
    logic [31:0]          wdat  = 32'h0;
    logic                 osc   = 1'b0;
    logic [1:0]           dsel  = scd_pkg::STYLE_SLOW;
    logic [7:0]           lvl   = 8'hFF;
    logic                 short = 1'b0;
    logic                 stby  = 1'b1;
    logic                 step  = 1'b0;
    logic [31:0]          rdat;
    logic                 ack;
    logic                 below;
    logic                 f_oe;
    logic                 h_oe;
    logic                 f_dat;
    logic                 h_dat;
    logic                 irq;
    scd_pkg::scd_bridge_s bridge;
    int                   fails = 0;
    int                   samples_checked = 0;
    int                   n;

    always #5 clk_i = ~clk_i;

    scd_top #(.RETRY_CYCLES(RETRY)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(stb), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .chop_osc_i(osc),
        .decay_select_i(dsel), .coil_below_i(below), .short_det_i(short),
        .standby_control_i(stby), .step_i(step), .bridge_o(bridge),
        .fault_output_o(f_dat), .fault_output_oe_n_o(f_oe),
        .hold_reduce_o(h_dat),
        .hold_reduce_oe_n_o(h_oe), .irq_o(irq)
    );
    scd_coil_model coil_u (.clk_i(clk_i), .rst_i(rst_i), .bridge_i(bridge),
                           .set_i(lvl), .coil_below_o(below));

    task automatic test_done();
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc_n(int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q);
        int k;
        k = 0;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        stb <= 1'b0;
        if (k >= 20) begin
            fails++;
            $display("Error bus_ack expected 1 seen %b", ack);
            test_done();
        end
        @(posedge clk_i);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    // Select 0 bridge enable, 1 fault drive, 2 hold drive
    task automatic wait_lvl(int s, logic v, output int k);
        logic g;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
            g = (s == 0) ? bridge.en : (s == 1) ? f_oe : h_oe;
        end while (g !== v && k < 400);
        if (k >= 400) begin
            fails++;
            $display("Error wait_%0d expected %b seen %b", s, v, g);
            test_done();
        end
    endtask

    initial begin
        cyc_n(5);
        rst_i <= 1'b0;
        cyc_n(1);
        chk("bridge_rst", 32'h0, {28'h0, bridge});
        rd_chk("ctrl", scd_pkg::ADDR_CTRL, scd_pkg::CTRL_RST);
        rd_chk("idle", scd_pkg::ADDR_IDLE, 32'h0393_8700);
        rd_chk("mask", scd_pkg::ADDR_IRQM, {28'h0, scd_pkg::IRQM_RST});
        wr(8'h20, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h20, 32'h0);
        for (int i = 0; i < 6; i++) begin
            osc <= 1'b1;
            cyc_n(50);
            osc <= 1'b0;
            chk("blank", 32'hC, {28'h0, bridge});
            cyc_n(150);
            chk("mid", {28'h0, ROWS[i].mid}, {28'h0, bridge});
            cyc_n(50);
            dsel <= ROWS[(i + 1) % 6].st;
            lvl  <= ROWS[(i + 1) % 6].lvl;
            cyc_n(145);
            chk("tail", {28'h0, ROWS[i].tail}, {28'h0, bridge});
            cyc_n(5);
        end
        // A brief short retries; a lasting one must latch
        short <= 1'b1;
        cyc_n(3);
        short <= 1'b0;
        wait_lvl(0, 1'b0, n);
        wait_lvl(0, 1'b1, n);
        chk("retry", 32'h1, {31'h0, n > RETRY - 6 && n < RETRY + 6});
        chk("no_latch", 32'h1, {31'h0, f_oe});
        short <= 1'b1;
        wait_lvl(1, 1'b0, n);
        chk("latch", 32'h1, {31'h0, n > RETRY && n < RETRY + 10});
        short <= 1'b0;
        cyc_n(20);
        chk("latch_off", 32'h0, {31'h0, bridge.en | f_oe});
        chk("od_low", 32'h0, {30'h0, f_dat, h_dat});
        stby <= 1'b0;
        wait_lvl(1, 1'b1, n);
        stby <= 1'b1;
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd_chk("irqs", scd_pkg::ADDR_IRQS, 32'hB);
        rd_chk("irqs_clr", scd_pkg::ADDR_IRQS, 32'h0);
        wr(scd_pkg::ADDR_IDLE, 32'h0000_0032);
        repeat (4) begin
            step <= 1'b1;
            cyc_n(10);
            step <= 1'b0;
            cyc_n(10);
        end
        cyc_n(22);
        chk("hold_early", 32'h1, {31'h0, h_oe});
        wait_lvl(2, 1'b0, n);
        chk("hold_time", 32'h1, {31'h0, n >= 4 && n <= 12});
        chk("irq_off", 32'h0, {31'h0, irq});
        wr(scd_pkg::ADDR_IRQM, 32'h4);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd_chk("irqs_hold", scd_pkg::ADDR_IRQS, 32'h4);
        chk("irq_clr", 32'h0, {31'h0, irq});
        step <= 1'b1;
        wait_lvl(2, 1'b1, n);
        chk("release", 32'h1, {31'h0, n <= 3});
        step <= 1'b0;
        cyc_n(30);
        chk("restart", 32'h1, {31'h0, h_oe});
        test_done();
    end
endmodule
